// [vectored_irq_ctrl_pkg.sv]
// Package: register offsets, field layouts and reset values of the interrupt controller
package vectored_irq_ctrl_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int REQ_COUNT = 32;
  localparam int SLOT_COUNT = 16;
  localparam int SRC_BITS = 5;
  localparam int SLOT_BITS = 4;

  // ****************************************
  // Register byte offsets (low twelve address bits)
  // ****************************************
  localparam logic [11:0] NORMAL_STATUS_OFS = 12'h000;
  localparam logic [11:0] FAST_STATUS_OFS = 12'h004;
  localparam logic [11:0] RAW_STATUS_OFS = 12'h008;
  localparam logic [11:0] CLASS_SELECT_OFS = 12'h00C;
  localparam logic [11:0] ENABLE_MASK_OFS = 12'h010;
  localparam logic [11:0] ENABLE_CLEAR_OFS = 12'h014;
  localparam logic [11:0] SOFT_BITS_OFS = 12'h018;
  localparam logic [11:0] SOFT_CLEAR_OFS = 12'h01C;
  localparam logic [11:0] ACTIVE_VECTOR_OFS = 12'h030;
  localparam logic [11:0] DEFAULT_HANDLER_OFS = 12'h034;
  localparam logic [5:0] SLOT_ADDR_PAGE = 6'h04;
  localparam logic [5:0] SLOT_CTRL_PAGE = 6'h08;

  // ****************************************
  // Slot control field layout
  // ****************************************
  localparam int SLOT_SRC_LSB = 0;
  localparam int SLOT_EN_BIT = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [5:0] SLOT_CTRL_RESET = 6'h00;

  // ****************************************
  // Bus answers
  // ****************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [3:0] FULL_WORD_STRB = 4'hF;

  typedef struct packed {
    logic enable;
    logic [SRC_BITS-1:0] source;
  } slot_ctrl_t;

  typedef struct packed {
    logic [REQ_COUNT-1:0] raw;
    logic [REQ_COUNT-1:0] fast;
    logic [REQ_COUNT-1:0] normal;
  } req_view_t;

endpackage

// [vectored_irq_ctrl.sv]
// Vectored interrupt controller with an AXI4-Lite register slave
// What this block does
// - 32 requests, each software-classified into one category
// - Fast requests outrank all normal requests
// - Fast output ORs enabled fast-class requests
// - Readable word of requesting fast sources
// - Sixteen vectored slots rank between fast, non-vectored
// - Any request to any slot; slot 0 highest
// - Unslotted enabled normal requests are non-vectored, lowest
// - Normal output ORs all active normal requests
// - Vector read returns highest active slot address
// - No active slot returns default handler address
// - Status register shows active normal requests
// - Registers are whole words only
// - Software can raise any of 32 requests
// - Soft bits ORed with lines before enabling
// - Select bit routes to fast, resets zero
// - Enable bits gate; write-ones clear register
module vectored_irq_ctrl
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [31:0] reqIn,
  output logic fastIrq,
  output logic normalIrq,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Configuration state
  // ****************************************
  logic [31:0] selectReg;
  logic [31:0] enableReg;
  logic [31:0] softReg;
  logic [31:0] defaultAddrReg;
  logic [31:0] vecAddrReg;
  logic [31:0] slotAddrReg [vectored_irq_ctrl_pkg::SLOT_COUNT];
  vectored_irq_ctrl_pkg::slot_ctrl_t slotCtrlReg [vectored_irq_ctrl_pkg::SLOT_COUNT];
  logic fastReg;
  logic normalReg;

  // ****************************************
  // Request classification
  // ****************************************
  vectored_irq_ctrl_pkg::req_view_t view;
  logic [31:0] enabledReq;

  assign view.raw = reqIn | softReg;
  assign enabledReq = view.raw & enableReg;
  assign view.fast = enabledReq & selectReg;
  assign view.normal = enabledReq & ~selectReg;

  // ****************************************
  // Slot priority chain
  // ****************************************
  // Chain runs from slot 15 up to slot 0 so the lowest index wins
  logic [vectored_irq_ctrl_pkg::SLOT_COUNT-1:0] slotHit;
  logic [vectored_irq_ctrl_pkg::SLOT_COUNT:0] chainFound;
  logic [31:0] chainAddr [vectored_irq_ctrl_pkg::SLOT_COUNT+1];

  assign chainFound[vectored_irq_ctrl_pkg::SLOT_COUNT] = 1'b0;
  assign chainAddr[vectored_irq_ctrl_pkg::SLOT_COUNT] = defaultAddrReg;

  genvar gi;
  generate
    for (gi = 0; gi < vectored_irq_ctrl_pkg::SLOT_COUNT; gi++)
    begin : gSlot
      assign slotHit[gi] = slotCtrlReg[gi].enable & view.normal[slotCtrlReg[gi].source];
      assign chainFound[gi] = slotHit[gi] | chainFound[gi+1];
      assign chainAddr[gi] = slotHit[gi] ? slotAddrReg[gi] : chainAddr[gi+1];
    end
  endgenerate

  // ****************************************
  // Outputs to the core
  // ****************************************
  // Registered so a glitching decode never reaches the core pins
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      fastReg <= 1'b0;
      normalReg <= 1'b0;
      vecAddrReg <= vectored_irq_ctrl_pkg::WORD_RESET;
    end
    else
    begin
      fastReg <= |view.fast;
      normalReg <= |view.normal;
      vecAddrReg <= chainAddr[0];
    end
  end

  assign fastIrq = fastReg;
  assign normalIrq = normalReg;

  // ****************************************
  // Write channel holding
  // ****************************************
  logic awHeld;
  logic wHeld;
  logic [11:0] awOfsReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic bvalidReg;
  logic [1:0] brespReg;
  logic commit;

  assign awready = ~awHeld;
  assign wready = ~wHeld;
  assign commit = awHeld & wHeld & ~bvalidReg;
  assign bvalid = bvalidReg;
  assign bresp = brespReg;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      awHeld <= 1'b0;
      awOfsReg <= 12'h000;
    end
    else if (awvalid & ~awHeld)
    begin
      awHeld <= 1'b1;
      awOfsReg <= awaddr[11:0];
    end
    else if (commit)
    begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wHeld <= 1'b0;
      wDataReg <= vectored_irq_ctrl_pkg::WORD_RESET;
      wStrbReg <= 4'h0;
    end
    else if (wvalid & ~wHeld)
    begin
      wHeld <= 1'b1;
      wDataReg <= wdata;
      wStrbReg <= wstrb;
    end
    else if (commit)
    begin
      wHeld <= 1'b0;
    end
  end

  // ****************************************
  // Write decode
  // ****************************************
  logic fullWord;
  logic wrSlotAddr;
  logic wrSlotCtrl;
  logic wrMapped;
  logic wrOk;
  logic [3:0] wrSlot;

  assign fullWord = wStrbReg == vectored_irq_ctrl_pkg::FULL_WORD_STRB;
  assign wrSlot = awOfsReg[5:2];
  assign wrSlotAddr = awOfsReg[11:6] == vectored_irq_ctrl_pkg::SLOT_ADDR_PAGE;
  assign wrSlotCtrl = awOfsReg[11:6] == vectored_irq_ctrl_pkg::SLOT_CTRL_PAGE;
  assign wrMapped = wrSlotAddr | wrSlotCtrl
    | awOfsReg == vectored_irq_ctrl_pkg::CLASS_SELECT_OFS
    | awOfsReg == vectored_irq_ctrl_pkg::ENABLE_MASK_OFS
    | awOfsReg == vectored_irq_ctrl_pkg::ENABLE_CLEAR_OFS
    | awOfsReg == vectored_irq_ctrl_pkg::SOFT_BITS_OFS
    | awOfsReg == vectored_irq_ctrl_pkg::SOFT_CLEAR_OFS
    | awOfsReg == vectored_irq_ctrl_pkg::ACTIVE_VECTOR_OFS
    | awOfsReg == vectored_irq_ctrl_pkg::DEFAULT_HANDLER_OFS;
  assign wrOk = commit & fullWord & wrMapped;

  // ****************************************
  // Write answer
  // ****************************************
  // Address miss outranks a partial strobe
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      bvalidReg <= 1'b0;
      brespReg <= vectored_irq_ctrl_pkg::RESP_OKAY;
    end
    else if (commit)
    begin
      bvalidReg <= 1'b1;
      brespReg <= ~wrMapped ? vectored_irq_ctrl_pkg::RESP_DECERR
        : fullWord ? vectored_irq_ctrl_pkg::RESP_OKAY : vectored_irq_ctrl_pkg::RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalidReg <= 1'b0;
    end
  end

  // ****************************************
  // Control register writes
  // ****************************************
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      selectReg <= vectored_irq_ctrl_pkg::WORD_RESET;
      enableReg <= vectored_irq_ctrl_pkg::WORD_RESET;
      softReg <= vectored_irq_ctrl_pkg::WORD_RESET;
      defaultAddrReg <= vectored_irq_ctrl_pkg::WORD_RESET;
    end
    else if (wrOk)
    begin
      if (awOfsReg == vectored_irq_ctrl_pkg::CLASS_SELECT_OFS)
        selectReg <= wDataReg;
      if (awOfsReg == vectored_irq_ctrl_pkg::ENABLE_MASK_OFS)
        enableReg <= enableReg | wDataReg;
      if (awOfsReg == vectored_irq_ctrl_pkg::ENABLE_CLEAR_OFS)
        enableReg <= enableReg & ~wDataReg;
      if (awOfsReg == vectored_irq_ctrl_pkg::SOFT_BITS_OFS)
        softReg <= softReg | wDataReg;
      if (awOfsReg == vectored_irq_ctrl_pkg::SOFT_CLEAR_OFS)
        softReg <= softReg & ~wDataReg;
      if (awOfsReg == vectored_irq_ctrl_pkg::DEFAULT_HANDLER_OFS)
        defaultAddrReg <= wDataReg;
    end
  end

  // ****************************************
  // Vector slot writes
  // ****************************************
  // One write per commit, so set and clear never meet
  generate
    for (gi = 0; gi < vectored_irq_ctrl_pkg::SLOT_COUNT; gi++)
    begin : gSlotWr
      always_ff @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          slotAddrReg[gi] <= vectored_irq_ctrl_pkg::WORD_RESET;
          slotCtrlReg[gi] <= vectored_irq_ctrl_pkg::SLOT_CTRL_RESET;
        end
        else if (wrOk & wrSlot == 4'(gi))
        begin
          if (wrSlotAddr)
            slotAddrReg[gi] <= wDataReg;
          if (wrSlotCtrl)
            slotCtrlReg[gi] <= wDataReg[vectored_irq_ctrl_pkg::SLOT_EN_BIT:vectored_irq_ctrl_pkg::SLOT_SRC_LSB];
        end
      end
    end
  endgenerate

  // ****************************************
  // Read decode
  // ****************************************
  // Reads carry no strobe, so every read of a mapped offset is a full word
  logic [11:0] rdOfs;
  logic [3:0] rdSlot;
  logic rdSlotAddr;
  logic rdSlotCtrl;
  logic rdMapped;
  logic [31:0] rdWord;
  logic rvalidReg;
  logic [31:0] rdataReg;
  logic [1:0] rrespReg;

  assign rdOfs = araddr[11:0];
  assign rdSlot = rdOfs[5:2];
  assign rdSlotAddr = rdOfs[11:6] == vectored_irq_ctrl_pkg::SLOT_ADDR_PAGE;
  assign rdSlotCtrl = rdOfs[11:6] == vectored_irq_ctrl_pkg::SLOT_CTRL_PAGE;
  assign rdMapped = rdSlotAddr | rdSlotCtrl
    | rdOfs == vectored_irq_ctrl_pkg::NORMAL_STATUS_OFS
    | rdOfs == vectored_irq_ctrl_pkg::FAST_STATUS_OFS
    | rdOfs == vectored_irq_ctrl_pkg::RAW_STATUS_OFS
    | rdOfs == vectored_irq_ctrl_pkg::CLASS_SELECT_OFS
    | rdOfs == vectored_irq_ctrl_pkg::ENABLE_MASK_OFS
    | rdOfs == vectored_irq_ctrl_pkg::SOFT_BITS_OFS
    | rdOfs == vectored_irq_ctrl_pkg::ACTIVE_VECTOR_OFS
    | rdOfs == vectored_irq_ctrl_pkg::DEFAULT_HANDLER_OFS;
  // Clear registers are write-only and read as zero
  assign rdWord =
    rdSlotAddr ? slotAddrReg[rdSlot]
    : rdSlotCtrl ? {26'h0, slotCtrlReg[rdSlot]}
    : rdOfs == vectored_irq_ctrl_pkg::NORMAL_STATUS_OFS ? view.normal
    : rdOfs == vectored_irq_ctrl_pkg::FAST_STATUS_OFS ? view.fast
    : rdOfs == vectored_irq_ctrl_pkg::RAW_STATUS_OFS ? view.raw
    : rdOfs == vectored_irq_ctrl_pkg::CLASS_SELECT_OFS ? selectReg
    : rdOfs == vectored_irq_ctrl_pkg::ENABLE_MASK_OFS ? enableReg
    : rdOfs == vectored_irq_ctrl_pkg::SOFT_BITS_OFS ? softReg
    : rdOfs == vectored_irq_ctrl_pkg::ACTIVE_VECTOR_OFS ? vecAddrReg
    : rdOfs == vectored_irq_ctrl_pkg::DEFAULT_HANDLER_OFS ? defaultAddrReg
    : vectored_irq_ctrl_pkg::WORD_RESET;

  // ****************************************
  // Read answer
  // ****************************************
  // Next read held off until the answer is taken
  assign arready = ~rvalidReg;
  assign rvalid = rvalidReg;
  assign rdata = rdataReg;
  assign rresp = rrespReg;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rvalidReg <= 1'b0;
      rdataReg <= vectored_irq_ctrl_pkg::WORD_RESET;
      rrespReg <= vectored_irq_ctrl_pkg::RESP_OKAY;
    end
    else if (arvalid & ~rvalidReg)
    begin
      rvalidReg <= 1'b1;
      rdataReg <= rdWord;
      rrespReg <= rdMapped ? vectored_irq_ctrl_pkg::RESP_OKAY : vectored_irq_ctrl_pkg::RESP_DECERR;
    end
    else if (rready)
    begin
      rvalidReg <= 1'b0;
    end
  end

endmodule

// [core_irq_model.sv]
// Behavioural model of the processor core's interrupt inputs
module core_irq_model
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic fastIrq,
  input wire logic normalIrq,
  output logic [1:0] takenKind
);
  timeunit 1ns;
  timeprecision 1ps;
  // Core takes the fast line ahead of the normal one
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      takenKind <= 2'h0;
    else
      takenKind <= fastIrq ? 2'h2 : (normalIrq ? 2'h1 : 2'h0);
  end
endmodule

// [vectored_irq_ctrl_chk.sv]
// Concurrent checks on the interrupt controller ports
module vectored_irq_ctrl_chk
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [31:0] reqIn,
  input wire logic fastIrq,
  input wire logic normalIrq,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Fast output only rises and normal output only falls on a request change or a committed write
  chk_fast_cause: assert property ($rose(fastIrq) |-> $past(reqIn) != $past(reqIn, 2) || $past(bvalid) || $past(bvalid, 2))
    else $error("fast output rose without cause");
  chk_normal_cause: assert property ($fell(normalIrq) |-> $past(reqIn) != $past(reqIn, 2) || $past(bvalid) || $past(bvalid, 2))
    else $error("normal output fell without cause");
  chk_quiet_release: assert property ($fell(rst) |-> !fastIrq && !normalIrq && !bvalid && !rvalid)
    else $error("outputs not quiet after reset");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered next cycle");
  chk_read_cause: assert property ($rose(rvalid) |-> $past(arvalid && arready))
    else $error("read answer without request");
  chk_part_write: assert property (wvalid && wready && wstrb != vectored_irq_ctrl_pkg::FULL_WORD_STRB |->
    ##[1:4] bvalid && bresp == vectored_irq_ctrl_pkg::RESP_SLVERR)
    else $error("partial write not refused");
  chk_status_ro: assert property (awvalid && awready && awaddr[11:0] == vectored_irq_ctrl_pkg::NORMAL_STATUS_OFS |->
    ##[1:4] bvalid && bresp == vectored_irq_ctrl_pkg::RESP_DECERR)
    else $error("status write not refused");
  chk_clear_zero: assert property (arvalid && arready && araddr[11:0] == vectored_irq_ctrl_pkg::ENABLE_CLEAR_OFS |=>
    rdata == 32'h0 && rresp == vectored_irq_ctrl_pkg::RESP_DECERR)
    else $error("clear register read not zero");
endmodule

// [tb_top.sv]
// Bench: bus tasks and interrupt scenarios for the controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
  logic ref_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] reqIn = 0, awaddr = 0, wdata = 0, araddr = 0, rdata;
  logic [3:0] wstrb = 0;
  logic [1:0] bresp, rresp, takenKind;
  logic fastIrq, normalIrq, awready, wready, bvalid, arready, rvalid;
  int fail_count = 0, cmp_count = 0;
  vectored_irq_ctrl i_vectored_irq_ctrl (.ref_clk, .rst, .reqIn, .fastIrq, .normalIrq, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  core_irq_model i_core_irq_model (.ref_clk, .rst, .fastIrq, .normalIrq, .takenKind);
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  // ****************************************
  // Bus tasks; bounded waits end the run
  // ****************************************
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] e);
    int n;
    n = 0;
    @(posedge ref_clk);
    awaddr <= {20'h0, a};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      summarize();
    end
    `CHK("bresp", e, bresp)
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    int n;
    n = 0;
    @(posedge ref_clk);
    araddr <= {20'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      summarize();
    end
    `CHK("rresp", e, rresp)
    `CHK("rdata", d, rdata)
  endtask
  // Controller outputs trail inputs by one clock, takenKind by two; three leaves margin
  task automatic settle;
    repeat (3) @(posedge ref_clk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(vectored_irq_ctrl_pkg::CLASS_SELECT_OFS, 32'h0, 2'h0);
    rd(vectored_irq_ctrl_pkg::ENABLE_MASK_OFS, 32'h0, 2'h0);
    wr(vectored_irq_ctrl_pkg::CLASS_SELECT_OFS, 32'h8000_0080, 4'hF, 2'h0);
    wr(vectored_irq_ctrl_pkg::ENABLE_MASK_OFS, 32'h8010_0288, 4'hF, 2'h0);
    wr(12'h108, 32'h0000_A9A9, 4'hF, 2'h0);
    wr(12'h208, 32'h0000_0029, 4'hF, 2'h0);
    wr(12'h114, 32'h0000_A3A3, 4'hF, 2'h0);
    wr(12'h214, 32'h0000_0023, 4'hF, 2'h0);
    wr(vectored_irq_ctrl_pkg::DEFAULT_HANDLER_OFS, 32'h0000_DEF0, 4'hF, 2'h0);
    reqIn <= 32'h8000_0088;
    settle();
    `CHK("fastIrq", 1'b1, fastIrq)
    `CHK("normalIrq", 1'b1, normalIrq)
    `CHK("takenKind", 2'h2, takenKind)
    rd(vectored_irq_ctrl_pkg::FAST_STATUS_OFS, 32'h8000_0080, 2'h0);
    rd(vectored_irq_ctrl_pkg::NORMAL_STATUS_OFS, 32'h0000_0008, 2'h0);
    rd(vectored_irq_ctrl_pkg::ACTIVE_VECTOR_OFS, 32'h0000_A3A3, 2'h0);
    reqIn <= 32'h0000_0208;
    settle();
    rd(vectored_irq_ctrl_pkg::ACTIVE_VECTOR_OFS, 32'h0000_A9A9, 2'h0);
    reqIn <= 32'h0;
    settle();
    `CHK("fastIrq", 1'b0, fastIrq)
    `CHK("normalIrq", 1'b0, normalIrq)
    wr(vectored_irq_ctrl_pkg::SOFT_BITS_OFS, 32'h0010_0000, 4'hF, 2'h0);
    settle();
    `CHK("normalIrq", 1'b1, normalIrq)
    `CHK("takenKind", 2'h1, takenKind)
    rd(vectored_irq_ctrl_pkg::RAW_STATUS_OFS, 32'h0010_0000, 2'h0);
    rd(vectored_irq_ctrl_pkg::ACTIVE_VECTOR_OFS, 32'h0000_DEF0, 2'h0);
    wr(vectored_irq_ctrl_pkg::CLASS_SELECT_OFS, 32'hFFFF_FFFF, 4'h1, 2'h2);
    rd(vectored_irq_ctrl_pkg::CLASS_SELECT_OFS, 32'h8000_0080, 2'h0);
    wr(vectored_irq_ctrl_pkg::ENABLE_CLEAR_OFS, 32'h0010_0000, 4'hF, 2'h0);
    settle();
    `CHK("normalIrq", 1'b0, normalIrq)
    rd(vectored_irq_ctrl_pkg::ENABLE_MASK_OFS, 32'h8000_0288, 2'h0);
    wr(vectored_irq_ctrl_pkg::SOFT_CLEAR_OFS, 32'h0010_0000, 4'hF, 2'h0);
    rd(vectored_irq_ctrl_pkg::SOFT_BITS_OFS, 32'h0, 2'h0);
    wr(vectored_irq_ctrl_pkg::NORMAL_STATUS_OFS, 32'h1, 4'hF, 2'h3);
    rd(12'hFF0, 32'h0, 2'h3);
    rd(vectored_irq_ctrl_pkg::ENABLE_CLEAR_OFS, 32'h0, 2'h3);
    summarize();
  end
endmodule
bind vectored_irq_ctrl vectored_irq_ctrl_chk i_vectored_irq_ctrl_chk (.ref_clk, .rst, .reqIn, .fastIrq, .normalIrq,
  .awaddr, .awvalid, .awready, .wstrb, .wvalid, .wready, .bresp, .bvalid, .araddr, .arvalid, .arready, .rdata, .rresp,
  .rvalid);
